//--- include/enc_map.svh
// offsets, field widths, reset values and counts of the encoder serial slave
// assumes inclusion by bare name from the design file and the property file
`ifndef ENC_MAP_SVH
`define ENC_MAP_SVH

// position word: multiturn above singleturn
`define ENC_MT_W        20
`define ENC_ST_W        12
`define ENC_POS_W       32

// frame image held in the link shift register
`define ENC_SH_W        48
`define ENC_CRC_W       6
`define ENC_CRC_POLY    7'h43
`define ENC_CRC_DATA_W  34

// control data from the master
`define ENC_CMD_W       16

// adaptive timeout counters
`define ENC_TO_W        16
`define ENC_TO_MAX      16'hffff
`define ENC_TO_MIN      16'h0001

// buffering of position samples
`define ENC_FIFO_W      32
`define ENC_FIFO_DEPTH  8
`define ENC_FIFO_AW     3

// incremental outputs: fine angle counts 8192 per turn
`define ENC_FINE_W      13
`define ENC_PPR_LO      256
`define ENC_PPR_HI      2048
`define ENC_CPR_PER_PPR 4
`define ENC_LO_SHIFT    3

// idle level of the data line
`define ENC_SLO_IDLE    1'b1

`endif

//--- include/enc_pkg.sv
// types of the encoder serial slave
// assumes enc_map.svh on the include path
package enc_pkg;
  // frame tracker in the system domain
  typedef enum logic [1:0] {
    ENC_IDLE,
    ENC_MEAS1,
    ENC_MEAS2,
    ENC_RUN
  } enc_state_t;
endpackage

//--- rtl/enc_slave.sv
// serial slave of an absolute encoder (ssi or biss) with position fifo
// assumes clk at 20 MHz, ma_clk from the master, idle high, stopped between
// frames; control inputs come from logic on clk
//
// Notes on behaviour
// - one position bit per master clock cycle.
// - ssi frame opens with a high start bit.
// - timeout equals first fall to second rise.
// - timeout after last rise clears shift register.
// - cdm bit per frame builds a command.
// - acknowledge: one low bit on the first master rise.
// - biss start bit high after acknowledge.
// - cds bit answers the cdm stream.
// - error bit high in error state.
// - warning bit high on warning condition.
// - crc with polynomial 0x43 over data.
// - incremental outputs 256 or 2048 ppr.
// - biss word: 20 bit multiturn, 12 singleturn.
`timescale 1ns/10ps
`include "enc_map.svh"

module enc_fifo #(
  parameter int WIDTH = `ENC_FIFO_W,
  parameter int DEPTH = `ENC_FIFO_DEPTH,
  parameter int AW    = `ENC_FIFO_AW
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      used;
  logic [AW:0]      next_used;
  logic             push;
  logic             pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];
  assign next_used = used + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // flags registered from the next count, so both are honest each cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      used      <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      used      <= next_used;
      in_ready  <= next_used != (AW+1)'(DEPTH);
      out_valid <= next_used != '0;
    end
  end
endmodule

module enc_slave (
  // system clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // serial link: master clock in, slave data out
  input  wire logic                    ma_clk,
  output logic                         slo,
  // position samples from the sensor front end
  input  wire logic                    pos_valid,
  output logic                         pos_ready,
  input  wire logic [`ENC_POS_W-1:0]   pos_data,
  // configuration and status
  input  wire logic                    mode_biss,
  input  wire logic                    err_in,
  input  wire logic                    warn_in,
  output logic      [`ENC_CMD_W-1:0]   biss_cmd,
  output logic      [`ENC_TO_W-1:0]    tout_len,
  // incremental outputs
  input  wire logic                    ppr_hi,
  input  wire logic [`ENC_FINE_W-1:0]  fine_angle,
  output logic                         inc_a,
  output logic                         inc_b,
  output logic                         inc_z
);
  enc_pkg::enc_state_t state;

  // master clock sampled as a level
  logic                    ma_s1;
  logic                    ma_s2;
  logic                    ma_d;
  logic                    ma_rise;
  logic                    ma_fall;
  logic [`ENC_TO_W-1:0]    meas;
  logic [`ENC_TO_W-1:0]    tcnt;
  logic                    tout;
  logic                    link_rstn;

  // words handed to the link, changed only at a timeout, and the fifo head they load from, which a push also changes
  logic [`ENC_POS_W-1:0]   snap;
  logic [`ENC_CRC_W-1:0]   snap_crc;
  logic                    snap_err;
  logic                    snap_warn;
  logic                    snap_cds;
  logic                    snap_biss;
  logic                    fifo_valid;
  logic [`ENC_POS_W-1:0]   fifo_data;

  // link domain
  logic                    loaded;
  logic [`ENC_SH_W-1:0]    sh;
  logic [`ENC_SH_W-1:0]    image;

  function automatic logic [`ENC_CRC_W-1:0] crc6(
    input logic [`ENC_CRC_DATA_W-1:0] d
  );
    logic [`ENC_CRC_W-1:0] c;
    logic                  fb;
    c = '0;
    for (int i = `ENC_CRC_DATA_W-1; i >= 0; i--) begin
      fb = c[`ENC_CRC_W-1] ^ d[i];
      c  = {c[`ENC_CRC_W-2:0], 1'b0};
      if (fb) begin
        c = c ^ 6'(`ENC_CRC_POLY); // x^6 term is the bit shifted out
      end
    end
    return c;
  endfunction

  function automatic logic [`ENC_ST_W-1:0] to_gray(
    input logic [`ENC_ST_W-1:0] b
  );
    return b ^ (b >> 1);
  endfunction

  enc_fifo #(
    .WIDTH (`ENC_FIFO_W),
    .DEPTH (`ENC_FIFO_DEPTH),
    .AW    (`ENC_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (pos_valid),
    .in_ready  (pos_ready),
    .in_data   (pos_data),
    .out_valid (fifo_valid),
    .out_ready (tout),
    .out_data  (fifo_data)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ma_s1 <= 1'b1;
      ma_s2 <= 1'b1;
      ma_d  <= 1'b1;
    end else begin
      ma_s1 <= ma_clk;
      ma_s2 <= ma_s1;
      ma_d  <= ma_s2;
    end
  end

  assign ma_rise = ma_s2 & ~ma_d;
  assign ma_fall = ~ma_s2 & ma_d;
  // hold time restarts on each rise; expiry ends the frame
  assign tout    = (state == enc_pkg::ENC_RUN) && !ma_rise &&
                   (tcnt >= tout_len);

  // frame tracker: measure, then run until the line rests
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state    <= enc_pkg::ENC_IDLE;
      meas     <= '0;
      tcnt     <= '0;
      tout_len <= `ENC_TO_MIN;
    end else begin
      unique case (state)
        enc_pkg::ENC_IDLE: begin
          meas <= `ENC_TO_MIN;
          if (ma_fall) begin
            state <= enc_pkg::ENC_MEAS1;
          end
        end
        enc_pkg::ENC_MEAS1: begin
          if (meas != `ENC_TO_MAX) begin
            meas <= meas + 1'b1;
          end
          if (ma_rise) begin
            state <= enc_pkg::ENC_MEAS2;
          end
        end
        enc_pkg::ENC_MEAS2: begin
          if (meas != `ENC_TO_MAX) begin
            meas <= meas + 1'b1;
          end
          if (ma_rise) begin
            tout_len <= meas;
            tcnt     <= '0;
            state    <= enc_pkg::ENC_RUN;
          end
        end
        enc_pkg::ENC_RUN: begin
          if (ma_rise) begin
            tcnt <= '0;
          end else if (tout) begin
            state <= enc_pkg::ENC_IDLE;
          end else if (tcnt != `ENC_TO_MAX) begin
            tcnt <= tcnt + 1'b1;
          end
        end
      endcase
    end
  end

  // link clear at expiry and while the clock rests low; flop, glitch free
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_rstn <= 1'b0;
    end else begin
      link_rstn <= !(tout || (state == enc_pkg::ENC_IDLE &&
                              !ma_s2 && !ma_d));
    end
  end

  // cdm is the line level at expiry, gathered msb first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      biss_cmd <= '0;
    end else if (tout && snap_biss) begin
      biss_cmd <= {biss_cmd[`ENC_CMD_W-2:0], ma_s2};
    end
  end

  // next frame's contents are fixed while the link clock rests
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      snap      <= '0;
      snap_crc  <= '0;
      snap_err  <= 1'b0;
      snap_warn <= 1'b0;
      snap_cds  <= 1'b0;
      snap_biss <= 1'b0;
    end else if (tout) begin
      if (fifo_valid) begin
        snap     <= fifo_data;
        snap_crc <= crc6({fifo_data, err_in, warn_in});
      end else begin
        snap_crc <= crc6({snap, err_in, warn_in});
      end
      snap_err  <= err_in;
      snap_warn <= warn_in;
      snap_cds  <= ma_s2;
      snap_biss <= mode_biss;
    end
  end

  // frame image, left aligned, tail of zeros
  always_comb begin
    image = '0;
    if (snap_biss) begin
      // ack low, start, cds, mt, st, err, warn, crc
      image[`ENC_SH_W-1 -: 43] = {1'b0, 1'b1, snap_cds, snap, snap_err,
                                  snap_warn, snap_crc};
    end else begin
      image[`ENC_SH_W-1 -: 13] = {1'b1,
                                  to_gray(snap[`ENC_ST_W-1:0])};
    end
  end

  // link side: shifts on master rises, idles high from the timeout until the first rise
  always_ff @(posedge ma_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      loaded <= 1'b0;
      sh     <= '0;
      slo    <= `ENC_SLO_IDLE;
    end else if (!loaded) begin
      loaded <= 1'b1;
      slo    <= image[`ENC_SH_W-1];
      sh     <= {image[`ENC_SH_W-2:0], 1'b0};
    end else begin
      slo    <= sh[`ENC_SH_W-1];
      sh     <= {sh[`ENC_SH_W-2:0], 1'b0};
    end
  end

  // quadrature from fine angle: 4 counts per pulse
  logic [`ENC_FINE_W-1:0] qcnt;
  logic                   next_a;
  logic                   next_b;
  logic                   next_z;

  always_comb begin
    qcnt   = ppr_hi ? fine_angle : (fine_angle >> `ENC_LO_SHIFT);
    next_a = qcnt[1];
    next_b = qcnt[1] ^ qcnt[0];
    next_z = (qcnt == '0);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inc_a <= 1'b0;
      inc_b <= 1'b0;
      inc_z <= 1'b0;
    end else begin
      inc_a <= next_a;
      inc_b <= next_b;
      inc_z <= next_z;
    end
  end
endmodule

//--- verif/enc_slave_properties.sv
// assertions on the ports of the encoder serial slave
// assumes bound to enc_slave; ma_clk idles high between frames
`timescale 1ns/10ps
`include "enc_map.svh"

module enc_slave_properties (
  // clocks and reset
  input wire logic                   clk,
  input wire logic                   rstn,
  input wire logic                   ma_clk,
  // link and fifo
  input wire logic                   slo,
  input wire logic                   pos_valid,
  input wire logic                   pos_ready,
  // status and incremental
  input wire logic [`ENC_CMD_W-1:0]  biss_cmd,
  input wire logic [`ENC_TO_W-1:0]   tout_len,
  input wire logic                   ppr_hi,
  input wire logic [`ENC_FINE_W-1:0] fine_angle,
  input wire logic                   inc_a,
  input wire logic                   inc_b,
  input wire logic                   inc_z
);
  logic [2:0]             ma_s;
  logic [7:0]             idle_cnt;
  logic [`ENC_FINE_W-1:0] cnt_now;
  assign cnt_now = ppr_hi ? fine_angle : (fine_angle >> 3);
  // same depth as the design's sync, so idle counts from the same edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ma_s <= 3'h7;
    else ma_s <= {ma_s[1:0], ma_clk};
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) idle_cnt <= 8'h00;
    else if (ma_s[2] != ma_s[1]) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hff) idle_cnt <= idle_cnt + 8'h01;
  end
  sequence frame_open;
    idle_cnt >= 8'h08;
  endsequence
  sequence lead_bits;
    slo or (!slo ##1 slo);
  endsequence
  chk_lead_bits: assert property (
    @(negedge ma_clk) disable iff (!rstn) frame_open |=> lead_bits)
    else $error("frame lead bits wrong");
  chk_slo_idle: assert property (@(posedge clk) disable iff (!rstn)
    idle_cnt > tout_len + 6 |-> slo) else $error("line not idle");
  chk_tout_frame: assert property (@(posedge clk) disable iff (!rstn)
    $changed(tout_len) |-> idle_cnt < 8'h08 && tout_len != 16'h0000)
    else $error("timeout length moved outside frame");
  chk_cmd_shift: assert property (@(posedge clk) disable iff (!rstn)
    $changed(biss_cmd) |-> biss_cmd[15:1] == $past(biss_cmd[14:0]))
    else $error("command not shifted");
  chk_ready_fall: assert property (@(posedge clk) disable iff (!rstn)
    $fell(pos_ready) |-> $past(pos_valid)) else $error("ready fell alone");
  chk_inc_a: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> inc_a == $past(cnt_now[1])) else $error("inc a wrong");
  chk_inc_b: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> inc_b == ($past(cnt_now[1]) ^ $past(cnt_now[0])))
    else $error("inc b wrong");
  chk_inc_z: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> inc_z == ($past(cnt_now) == 13'h0000)) else $error("inc z");
endmodule

bind enc_slave enc_slave_properties u_enc_slave_properties (
  .clk(clk), .rstn(rstn), .ma_clk(ma_clk), .slo(slo),
  .pos_valid(pos_valid), .pos_ready(pos_ready), .biss_cmd(biss_cmd),
  .tout_len(tout_len), .ppr_hi(ppr_hi), .fine_angle(fine_angle),
  .inc_a(inc_a), .inc_b(inc_b), .inc_z(inc_z));

//--- verif/enc_master_model.sv
// master of the serial link: makes the clock and reads the data line
// assumes slo changes on rising ma_clk; clock idles high between frames
`timescale 1ns/10ps

module enc_master_model #(
  parameter int HALF_NS = 127
) (
  // link
  output logic      ma_clk,
  input  wire logic slo
);
  initial ma_clk = 1'b1;
  // n bits, msb first into got; line then held at lvl past the timeout
  task automatic frame(input int n, input logic lvl,
                       output logic [63:0] got);
    got = 64'h0;
    ma_clk = 1'b0;
    for (int i = 0; i < n; i++) begin
      #(HALF_NS) ma_clk = 1'b1;
      #(HALF_NS) got = {got[62:0], slo};
      if (i < n - 1) ma_clk = 1'b0;
    end
    ma_clk = lvl;
    #(80 * HALF_NS) ma_clk = 1'b1;
    #(80 * HALF_NS);
  endtask
endmodule

//--- verif/testbench.sv
// self-checking bench of the encoder serial slave
// assumes the master model makes the link clock
`timescale 1ns/10ps

module testbench;
  logic        clk, rstn, ma_clk, slo, pos_valid, pos_ready, mode_biss;
  logic        err_in, warn_in, ppr_hi, inc_a, inc_b, inc_z;
  logic [31:0] pos_data;
  logic [15:0] biss_cmd, tout_len;
  logic [12:0] fine_angle;
  logic [63:0] got;
  int          err_total = 0;
  int          num_checks = 0;
  enc_slave u_enc_slave (.clk(clk), .rstn(rstn), .ma_clk(ma_clk), .slo(slo),
    .pos_valid(pos_valid), .pos_ready(pos_ready), .pos_data(pos_data),
    .mode_biss(mode_biss), .err_in(err_in), .warn_in(warn_in),
    .biss_cmd(biss_cmd), .tout_len(tout_len), .ppr_hi(ppr_hi),
    .fine_angle(fine_angle), .inc_a(inc_a), .inc_b(inc_b), .inc_z(inc_z));
  enc_master_model u_enc_master_model (.ma_clk(ma_clk), .slo(slo));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic cmp(input logic [63:0] g, e, input string m);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  function automatic logic [5:0] crc6(input logic [33:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 33; i >= 0; i--)
      c = {c[4:0], 1'b0} ^ ((c[5] ^ d[i]) ? 6'h03 : 6'h00);
    return c;
  endfunction
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic push(input logic [31:0] w);
    @(negedge clk);
    pos_valid = 1'b1;
    pos_data = w;
    @(negedge clk);
    pos_valid = 1'b0;
  endtask
  task automatic t_inc;
    logic [13:0] v [4] = '{14'h2003, 14'h0010, 14'h0007, 14'h3000};
    logic [2:0]  e [4] = '{3'b100, 3'b110, 3'b001, 3'b000};
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      {ppr_hi, fine_angle} = v[i];
      repeat (2) @(negedge clk);
      cmp({inc_a, inc_b, inc_z}, e[i], "inc");
    end
  endtask
  // fill to refusal; the refused word must never reach the line
  task automatic t_fill;
    for (int i = 0; i < 8; i++)
      push(32'(32'h1000 * (i + 1) + 32'h0a5 + 32'h111 * i));
    cmp(pos_ready, 0, "full");
    push(32'hffff_ffff);
  endtask
  task automatic t_ssi;
    logic [11:0] s;
    u_enc_master_model.frame(16, 1'b1, got);
    cmp(got[15:0], 16'h8000, "ssi zero");
    cmp(tout_len >= 16'h0006 && tout_len <= 16'h0009, 1, "tout");
    for (int i = 0; i < 9; i++) begin
      s = 12'(12'h0a5 + 12'h111 * (i > 7 ? 7 : i));
      u_enc_master_model.frame(16, 1'b1, got);
      cmp(got[15:0], {1'b1, s ^ (s >> 1), 3'b000}, "ssi");
      cmp(slo, 1, "idle");
    end
  endtask
  task automatic t_biss;
    logic [31:0] p;
    logic [15:0] c;
    logic [33:0] d;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      mode_biss = 1'b1;
      err_in = k[0];
      warn_in = k[1];
      p = 32'h9abc_d5a3 ^ 32'(k << 4);
      push(p);
      c = biss_cmd;
      u_enc_master_model.frame(46, k[0], got);
      if (k > 0) begin
        cmp(biss_cmd, {c[14:0], k[0]}, "cmd");
        cmp(got[45:44], 2'b01, "ack start");
        cmp(got[43], c[0], "cds");
        cmp(got[42:0], {d, crc6(d), 3'b000}, "data");
      end
      d = {p, k[0], k[1]};
    end
  endtask
  initial begin
    #1_000_000;
    err_total++;
    finish_test();
  end
  initial begin
    rstn = 1'b0;
    pos_valid = 1'b0;
    pos_data = 32'h0;
    mode_biss = 1'b0;
    err_in = 1'b0;
    warn_in = 1'b0;
    ppr_hi = 1'b0;
    fine_angle = 13'h0000;
    repeat (6) @(negedge clk);
    cmp({slo, pos_ready, biss_cmd, tout_len, inc_a, inc_b, inc_z},
        {2'b10, 16'h0000, 16'h0001, 3'b000}, "reset");
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    cmp(pos_ready, 1, "ready");
    t_inc();
    t_fill();
    t_ssi();
    t_biss();
    finish_test();
  end
endmodule
